// file: core/crb_top.sv
// Configurable 1:1 / 1:2 registered address and command buffer
`timescale 1ns/1ps
module crb_top
    import crb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic buffer_reset_n,
    input wire logic bus_clk_p,
    input wire logic bus_clk_n,
    input wire logic pinout_select,
    input wire logic width_select,
    input wire logic device_chip_select_n,
    input wire logic chip_select_redundant_n,
    input wire logic [crb_pkg::DATA_W-1:0] data_in,
    input wire logic term_enable_in,
    input wire logic clock_enable_in,
    input wire logic sink_ready,
    output logic [crb_pkg::DATA_W-1:0] data_out,
    output logic [crb_pkg::SIDE_W-1:0] chip_select_out,
    output logic [crb_pkg::SIDE_W-1:0] term_enable_out,
    output logic [crb_pkg::SIDE_W-1:0] clock_enable_out,
    output logic out_strobe,
    output logic capture_ready,
    output logic overflow
);
    import crb_pkg::*;

    typedef struct packed {
        logic clk_prev;
        logic flush;
        logic strobe;
        logic ready;
        logic overflow;
        crb_word_t last;
        crb_word_t outw;
    } crb_top_st_t;

    localparam crb_top_st_t ST_RST = '{
        clk_prev: 1'b0,
        flush: 1'b1,
        strobe: 1'b0,
        ready: 1'b0,
        overflow: 1'b0,
        last: WORD_RST,
        outw: WORD_RST
    };

    crb_top_st_t q;
    crb_top_st_t d;
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] st;
    logic crossing;
    logic gate;
    crb_mode_t mode;
    crb_word_t word;
    logic [HALF_W-1:0] lane;
    logic [HALF_W-1:0] lane_rev;

    crb_stream_if #(.W(WORD_W)) cap_ch ();
    crb_stream_if #(.W(WORD_W)) out_ch ();

    // Order must match the pin positions named in the package
    assign pins = {width_select, pinout_select, bus_clk_n, bus_clk_p,
        chip_select_redundant_n, device_chip_select_n, clock_enable_in,
        term_enable_in, data_in};

    // All pins share one synchroniser so data stays aligned to the edge
    crb_sync #(.W(SYNC_W)) u_sync (
        .clk(ref_clk),
        .arst_n(buffer_reset_n),
        .pins(pins),
        .stable(st)
    );

    crb_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .flush(q.flush || rst),
        .in_port(cap_ch),
        .out_port(out_ch)
    );

    // Pair seen as one clock: high only when true side up, complement down
    assign crossing = st[PIN_CLKP] && !st[PIN_CLKN]
        && !q.clk_prev;
    assign gate = st[PIN_DCS] && st[PIN_CSR];
    assign mode = crb_mode_t'({st[PIN_C0], st[PIN_C1]});
    assign lane = st[PIN_DATA +: HALF_W];

    always_comb begin
        lane_rev = '0;
        // Back-side pinout mirrors the lane order across the package
        for (int i = 0; i < HALF_W; i++) begin
            lane_rev[i] = lane[HALF_W-1-i];
        end
    end

    always_comb begin
        word = q.last;
        // Side bits follow their inputs on every crossing; outside the two 1:2 modes the upper copy stays low
        case (mode)
            CRB_MODE_FRONT, CRB_MODE_BACK: begin
                word.cs = {SIDE_W{st[PIN_DCS]}};
                word.odt = {SIDE_W{st[PIN_ODT]}};
                word.cke = {SIDE_W{st[PIN_CKE]}};
            end
            default: begin
                word.cs = {1'b0, st[PIN_DCS]};
                word.odt = {1'b0, st[PIN_ODT]};
                word.cke = {1'b0, st[PIN_CKE]};
            end
        endcase
        // Ordinary data only moves while a chip select is low
        if (!gate) begin
            case (mode)
                CRB_MODE_1TO1: word.data = st[PIN_DATA +: DATA_W];
                CRB_MODE_FRONT: word.data = {lane, lane};
                CRB_MODE_BACK: word.data = {lane_rev, lane_rev};
                default: word.data = q.last.data;
            endcase
        end
    end

    assign cap_ch.valid = crossing;
    assign cap_ch.data = word;
    assign out_ch.ready = sink_ready;

    always_comb begin
        d = q;
        d.flush = 1'b0;
        d.strobe = 1'b0;
        d.clk_prev = st[PIN_CLKP] && !st[PIN_CLKN];
        d.ready = cap_ch.ready;
        if (crossing) begin
            if (cap_ch.ready) begin
                d.last = word;
            end else begin
                // Pins cannot stall, so a full buffer drops the word
                d.overflow = 1'b1;
            end
        end
        // Outputs change only by a drained word, i.e. only after a crossing
        if (out_ch.valid && sink_ready) begin
            d.outw = out_ch.data;
            d.strobe = 1'b1;
        end
        if (rst) begin
            d = ST_RST;
        end
    end

    // Pin reset acts without the clock and wins over every other term
    always_ff @(posedge ref_clk or negedge buffer_reset_n) begin
        if (!buffer_reset_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign data_out = q.outw.data;
    assign chip_select_out = q.outw.cs;
    assign term_enable_out = q.outw.odt;
    assign clock_enable_out = q.outw.cke;
    assign out_strobe = q.strobe;
    assign capture_ready = q.ready;
    assign overflow = q.overflow;
endmodule

// file: core/crb_pkg.sv
// Shared widths, bit positions, modes and word layout of the buffer
package crb_pkg;
    localparam int DATA_W = 22;
    localparam int HALF_W = 11;
    localparam int SIDE_W = 2;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_W = DATA_W + 3 * SIDE_W;
    // Positions inside the synchronised pin vector
    localparam int PIN_DATA = 0;
    localparam int PIN_ODT = DATA_W;
    localparam int PIN_CKE = DATA_W + 1;
    localparam int PIN_DCS = DATA_W + 2;
    localparam int PIN_CSR = DATA_W + 3;
    localparam int PIN_CLKP = DATA_W + 4;
    localparam int PIN_CLKN = DATA_W + 5;
    localparam int PIN_C0 = DATA_W + 6;
    localparam int PIN_C1 = DATA_W + 7;
    localparam int SYNC_W = DATA_W + 8;

    // Index is {pinout_select, width_select}
    typedef enum logic [1:0] {
        CRB_MODE_1TO1 = 2'h0,
        CRB_MODE_FRONT = 2'h1,
        CRB_MODE_BACK = 2'h3,
        CRB_MODE_RSVD = 2'h2
    } crb_mode_t;

    typedef struct packed {
        logic [SIDE_W-1:0] cs;
        logic [SIDE_W-1:0] odt;
        logic [SIDE_W-1:0] cke;
        logic [DATA_W-1:0] data;
    } crb_word_t;

    localparam crb_word_t WORD_RST = '0;
    localparam logic [SYNC_W-1:0] PINS_RST = '0;
endpackage

// file: core/crb_stream_if.sv
// Valid/ready word channel between the buffer's own modules
`timescale 1ns/1ps
interface crb_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: core/crb_sync.sv
// Three-stage pin synchroniser with agreement filter, cleared by reset
`timescale 1ns/1ps
module crb_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] st;
    } crb_sync_st_t;

    crb_sync_st_t q;
    crb_sync_st_t d;

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Only the second and third stages vote; the first stays private
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.st[i] = q.s3[i];
            end
        end
    end

    // Held clear while reset is low: receivers off, floating pins ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stable = q.st;
endmodule

// file: core/crb_fifo.sv
// Word FIFO with flush, valid/ready on both sides
`timescale 1ns/1ps
module crb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic flush,
    crb_stream_if.snk in_port,
    crb_stream_if.src out_port
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } crb_fifo_st_t;

    crb_fifo_st_t q;
    crb_fifo_st_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_port.ready = (q.cnt != FULL_CNT);
    assign out_port.valid = (q.cnt != '0);
    assign out_port.data = mem[q.rd];
    assign push = in_port.valid && in_port.ready;
    assign pop = out_port.valid && out_port.ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wr = (q.wr == LAST_IDX) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == LAST_IDX) ? '0 : q.rd + 1'b1;
        end
        case ({push, pop})
            2'h2: d.cnt = q.cnt + 1'b1;
            2'h1: d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
        if (flush) begin
            d = '0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
        if (push) begin
            mem[q.wr] <= in_port.data;
        end
    end
endmodule

// file: tb/crb_checker.sv
// Pin-level assertions for the registered buffer
`timescale 1ns/1ps
module crb_checker
    import crb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic buffer_reset_n,
    input wire logic bus_clk_p,
    input wire logic bus_clk_n,
    input wire logic pinout_select,
    input wire logic width_select,
    input wire logic device_chip_select_n,
    input wire logic chip_select_redundant_n,
    input wire logic [crb_pkg::DATA_W-1:0] data_in,
    input wire logic term_enable_in,
    input wire logic clock_enable_in,
    input wire logic sink_ready,
    input wire logic [crb_pkg::DATA_W-1:0] data_out,
    input wire logic [crb_pkg::SIDE_W-1:0] chip_select_out,
    input wire logic [crb_pkg::SIDE_W-1:0] term_enable_out,
    input wire logic [crb_pkg::SIDE_W-1:0] clock_enable_out,
    input wire logic out_strobe,
    input wire logic capture_ready,
    input wire logic overflow
);
    logic [HALF_W-1:0] rev;
    logic [27:0] all_q;
    wire gated = device_chip_select_n && chip_select_redundant_n;
    wire upd = out_strobe && !device_chip_select_n;
    wire [1:0] mode = {pinout_select, width_select};
    wire [1:0] side_in = {term_enable_in, clock_enable_in};
    // Pins still hold the word when it leaves, host keeps them long
    always_comb rev = {<<{data_in[HALF_W-1:0]}};
    assign all_q = {chip_select_out, term_enable_out, clock_enable_out,
        data_out};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !buffer_reset_n);
    property p_arst; disable iff (1'b0) !buffer_reset_n |-> all_q == '0;
    endproperty
    property p_hold; !out_strobe |-> $stable(all_q); endproperty
    property p_gate; out_strobe && gated |-> $stable(data_out); endproperty
    property p_cs; out_strobe |-> chip_select_out[0] == device_chip_select_n;
    endproperty
    property p_side; out_strobe |-> {term_enable_out[0], clock_enable_out[0]}
        == side_in; endproperty
    property p_one; upd && mode == CRB_MODE_1TO1 |-> data_out == data_in;
    endproperty
    property p_front; upd && mode == CRB_MODE_FRONT
        |-> data_out == {2{data_in[HALF_W-1:0]}}; endproperty
    property p_back; upd && mode == CRB_MODE_BACK |-> data_out == {2{rev}};
    endproperty
    property p_cap; $rose(bus_clk_p) && sink_ready |-> ##[4:8] out_strobe;
    endproperty
    a_arst: assert property (p_arst) else $error("reset");
    a_hold: assert property (p_hold) else $error("hold");
    a_gate: assert property (p_gate) else $error("gate");
    a_cs: assert property (p_cs) else $error("cs");
    a_side: assert property (p_side) else $error("side");
    a_one: assert property (p_one) else $error("one");
    a_front: assert property (p_front) else $error("front");
    a_back: assert property (p_back) else $error("back");
    a_cap: assert property (p_cap) else $error("capture");
    c_gate: cover property (out_strobe && gated);
    c_full: cover property ($rose(overflow));
    c_back: cover property (upd && mode == CRB_MODE_BACK);
endmodule
bind crb_top crb_checker i_crb_checker (.*);

// file: tb/crb_host.sv
// Host-side pin driver for the buffer
`timescale 1ns/1ps
module crb_host
    import crb_pkg::*;
(
    input wire logic ref_clk,
    output logic bus_clk_p,
    output logic bus_clk_n,
    output logic [crb_pkg::DATA_W-1:0] data_in,
    output logic term_enable_in,
    output logic clock_enable_in,
    output logic device_chip_select_n,
    output logic chip_select_redundant_n
);
    // Clock parked low so a reset release sees no false crossing
    initial begin
        {bus_clk_p, data_in, term_enable_in, clock_enable_in} = '0;
        {device_chip_select_n, chip_select_redundant_n} = 2'h0;
        bus_clk_n = 1'b1;
    end
    // Data and side inputs low and clock parked before the receivers come back on; chip selects keep their levels
    task automatic park;
        {bus_clk_p, data_in, term_enable_in, clock_enable_in} = '0;
        bus_clk_n = 1'b1;
    endtask
    // Pins settle well around the crossing: they pass a synchroniser
    task automatic send(input logic [DATA_W-1:0] d, input logic [3:0] c);
        @(negedge ref_clk);
        {device_chip_select_n, chip_select_redundant_n} = c[3:2];
        {term_enable_in, clock_enable_in} = c[1:0];
        data_in = d;
        repeat (5) @(negedge ref_clk);
        {bus_clk_p, bus_clk_n} = 2'h2;
        repeat (8) @(negedge ref_clk);
        {bus_clk_p, bus_clk_n} = 2'h1;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// file: tb/crb_top_tb.sv
// Self-checking bench for the registered buffer
`timescale 1ns/1ps
module crb_top_tb;
    import crb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic buffer_reset_n = 1'b1;
    logic pinout_select = 1'b0;
    logic width_select = 1'b0;
    logic sink_ready = 1'b1;
    logic [DATA_W-1:0] data_in, data_out;
    logic [SIDE_W-1:0] chip_select_out, term_enable_out, clock_enable_out;
    logic bus_clk_p, bus_clk_n, term_enable_in, clock_enable_in;
    logic device_chip_select_n, chip_select_redundant_n;
    logic out_strobe, capture_ready, overflow;
    logic [27:0] outs;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    assign outs = {chip_select_out, term_enable_out, clock_enable_out,
        data_out};
    always #25 ref_clk = ~ref_clk;
    crb_top i_crb_top (.*);
    crb_host i_crb_host (.*);
    task automatic cmp(input string n, input logic [27:0] e,
        input logic [27:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic xfer(input logic [DATA_W-1:0] d, input logic [3:0] c);
        int n;
        n = 0;
        fork
            i_crb_host.send(d, c);
            while (out_strobe !== 1'b1 && n < 30) begin
                @(negedge ref_clk);
                n++;
            end
        join
        if (n == 30) cmp("strobe", 28'h1, 28'h0);
    endtask
    task automatic t_modes;
        logic [DATA_W-1:0] d;
        logic [HALF_W-1:0] r;
        d = 22'h2A5C3F;
        cmp("init", 28'h0, outs);
        xfer(d, 4'h2);
        cmp("one", {6'h04, d}, outs);
        width_select = 1'b1;
        xfer(d, 4'h2);
        cmp("front", {6'h0C, {2{d[HALF_W-1:0]}}}, outs);
        pinout_select = 1'b1;
        d = ~d;
        r = {<<{d[HALF_W-1:0]}};
        xfer(d, 4'h1);
        cmp("back", {6'h03, r, r}, outs);
        {pinout_select, width_select} = 2'h0;
    endtask
    task automatic t_gate;
        xfer(22'h0, 4'h0);
        xfer(22'h3FFFFF, 4'hF);
        cmp("gated", 28'h5400000, outs);
        xfer(22'h3FFFFF, 4'h8);
        cmp("one_low", 28'h43FFFFF, outs);
    endtask
    task automatic t_stall;
        int n;
        n = 0;
        sink_ready = 1'b0;
        repeat (FIFO_DEPTH + 1) i_crb_host.send(22'h155, 4'h0);
        cmp("full", 28'h1, {27'h0, overflow & ~capture_ready});
        sink_ready = 1'b1;
        repeat (40) begin
            @(negedge ref_clk);
            if (out_strobe === 1'b1) n++;
        end
        cmp("drain", 28'(FIFO_DEPTH), 28'(n));
    endtask
    task automatic t_reset;
        buffer_reset_n = 1'b0;
        @(negedge ref_clk);
        cmp("reset", 28'h0, outs);
        cmp("ovf", 28'h0, {27'h0, overflow});
        i_crb_host.park;
        buffer_reset_n = 1'b1;
        @(negedge ref_clk);
        xfer(22'h0AB, 4'h0);
        cmp("after", 28'h00000AB, outs);
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        t_modes;
        t_gate;
        t_stall;
        t_reset;
        end_sim;
    end
    // Whole run is about a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim;
        end
    end
endmodule
